// ---- common/tcs_pkg.sv ----
package tcs_pkg;

    // per-configuration field widths
    localparam int PREDIV_W  = 17;
    localparam int LOWDIV_W  = 17;
    localparam int UPINT_W   = 8;
    localparam int UPFRAC_W  = 18;
    localparam int OUTDIV_W  = 11;
    localparam int TUNE_W    = 7;

    localparam logic [1:0] MODE_LBW   = 2'h0;
    localparam logic [1:0] MODE_SYNTH = 2'h1;
    localparam logic [1:0] POL_PIN    = 2'h0;
    localparam logic [1:0] POL_NONREV = 2'h1;
    localparam logic [1:0] POL_REV    = 2'h2;
    localparam logic [1:0] POL_REG    = 2'h3;

    // adc divide ratio for code 0, as a shift amount of the crystal clock; each code step halves it
    localparam logic [2:0] ADC_SHIFT0 = 3'h4;

    // lock window base for code 0, in microseconds and in core cycles; each code step doubles it
    localparam int LOCK_WINDOW_FIELD_BASE_US = 2;
    localparam int CLK_MHZ         = 25;
    localparam int LOCK_WINDOW_FIELD_BASE_CYC = LOCK_WINDOW_FIELD_BASE_US * CLK_MHZ;

    typedef enum logic [1:0] {
        TCS_LBW   = 2'h0,
        TCS_SYNTH = 2'h1,
        TCS_HBW   = 2'h3
    } tcs_mode_t;

    typedef struct packed {
        logic                out_b_signalling_sel;
        logic                out_a_signalling_sel;
        logic [PREDIV_W-1:0] ref_prediv;
        logic [LOWDIV_W-1:0] lower_loop_int_div;
        logic [UPINT_W-1:0]  upper_loop_int_div;
        logic [UPFRAC_W-1:0] upper_loop_frac_div;
        logic [OUTDIV_W-1:0] output_divider;
        logic [TUNE_W-1:0]   loop_tuning_bits;
    } tcs_cfg_t;

    typedef struct packed {
        logic [1:0] pll_mode;
        logic       cfg_from_reg;
        logic       cfg_reg_sel;
        logic       out_a_enable;
        logic       out_b_enable;
        logic [1:0] input_choice_policy;
        logic       clock_choice;
        logic [1:0] adc_rate;
        logic [1:0] lock_window_field;
        logic       crystal_doubler;
    } tcs_glob_t;

    typedef struct packed {
        logic input_a_fail_flag;
        logic input_b_fail_flag;
        logic crystal_fail_flag;
        logic pll_locked_flag;
        logic frozen_tracking_flag;
        logic active_input;
    } tcs_stat_t;

    localparam tcs_cfg_t  CFG_RST  = '0;
    localparam tcs_glob_t GLOB_RST = '0;
    localparam tcs_stat_t STAT_RST = '0;

endpackage

// ---- rtl/tcs_cfg_set.sv ----
`timescale 1ns/1ps
`default_nettype none
module tcs_cfg_set
    import tcs_pkg::*;
(
    // clock and reset
    input  wire logic     i_core_clk,
    input  wire logic     i_rst_n,
    input  wire logic     i_ce,
    // write port
    input  wire logic     i_wr,
    input  wire tcs_cfg_t i_wdata,
    // stored set
    output tcs_cfg_t      o_cfg
);
    typedef struct packed {
        tcs_cfg_t cfg;
    } tcs_set_st_t;

    tcs_set_st_t st_q;
    tcs_set_st_t st_d;

    always_comb begin
        st_d = st_q;
        if (i_wr) begin
            st_d.cfg = i_wdata;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            st_q <= '{cfg: CFG_RST};
        end else if (i_ce) begin
            st_q <= st_d;
        end
    end

    assign o_cfg = st_q.cfg;
endmodule
`default_nettype wire

// ---- rtl/tcs_bank.sv ----
`timescale 1ns/1ps
`default_nettype none
module tcs_bank
    import tcs_pkg::*;
(
    // clock and reset
    input  wire logic        i_core_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_ce,
    // configuration set write ports
    input  wire logic        i_cfg0_wr,
    input  wire logic        i_cfg1_wr,
    input  wire tcs_cfg_t    i_cfg_wdata,
    // global control write port
    input  wire logic        i_glob_wr,
    input  wire tcs_glob_t   i_glob_wdata,
    // pins
    input  wire logic        i_config_pin,
    input  wire logic        i_out_a_en_pin,
    input  wire logic        i_out_b_en_pin,
    input  wire logic        i_input_sel_pin,
    // analog condition monitors
    input  wire logic        i_input_a_bad,
    input  wire logic        i_input_b_bad,
    input  wire logic        i_crystal_bad,
    input  wire logic        i_pll_locked,
    input  wire logic        i_pd_out_of_spec,
    // stored registers readback
    output tcs_cfg_t         o_cfg0,
    output tcs_cfg_t         o_cfg1,
    output tcs_glob_t        o_glob,
    output tcs_stat_t        o_stat,
    // active configuration toward the loop
    output logic             o_active_cfg,
    output tcs_cfg_t         o_cfg_active,
    output tcs_mode_t        o_mode,
    output logic             o_out_a_on,
    output logic             o_out_b_on,
    output logic             o_out_a_lvds,
    output logic             o_out_b_lvds,
    output logic             o_lower_loop_used,
    output logic [4:0]       o_adc_div,
    output logic [9:0]       o_lock_win_cyc,
    output logic             o_crystal_x2,
    output logic             o_osc_freeze,
    // status pins
    output logic             o_input_a_fail_pin,
    output logic             o_input_b_fail_pin,
    output logic             o_crystal_fail_pin,
    output logic             o_lock_pin,
    output logic             o_frozen_tracking_flag_pin,
    output logic             o_active_input_pin
);
    localparam logic [1:0] WIN_SHIFT_MAX = 2'h3;

    typedef struct packed {
        tcs_glob_t  glob;
        tcs_stat_t  stat;
        logic       active_cfg;
        tcs_cfg_t   cfg_act;
        tcs_mode_t  mode;
        logic       out_a_on;
        logic       out_b_on;
        logic [4:0] adc_div;
        logic [9:0] win_cyc;
    } tcs_st_t;

    tcs_st_t  st_q;
    tcs_st_t  st_d;
    tcs_cfg_t cfg0;
    tcs_cfg_t cfg1;
    logic     sel_now;

    // both sets share one module so their behaviour cannot drift apart
    tcs_cfg_set u_set0 (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .i_ce       (i_ce),
        .i_wr       (i_cfg0_wr),
        .i_wdata    (i_cfg_wdata),
        .o_cfg      (cfg0)
    );

    tcs_cfg_set u_set1 (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .i_ce       (i_ce),
        .i_wr       (i_cfg1_wr),
        .i_wdata    (i_cfg_wdata),
        .o_cfg      (cfg1)
    );

    function automatic tcs_mode_t decode_mode(input logic [1:0] code);
        tcs_mode_t m;
        m = TCS_HBW;
        if (code == MODE_LBW) begin
            m = TCS_LBW;
        end else if (code == MODE_SYNTH) begin
            m = TCS_SYNTH;
        end
        return m;
    endfunction

    // picks the clock input that policy and flags call for
    function automatic logic pick_input(
        input logic [1:0] pol,
        input logic       choice,
        input logic       pin,
        input logic       cur,
        input logic       bad_a,
        input logic       bad_b
    );
        logic r;
        logic pri_bad;
        logic cur_bad;
        r       = cur;
        pri_bad = choice ? bad_b : bad_a;
        cur_bad = cur ? bad_b : bad_a;
        unique case (pol)
            POL_PIN:    r = pin;
            POL_REG:    r = choice;
            POL_REV:    r = pri_bad ? ~choice : choice;
            POL_NONREV: r = cur_bad ? ~cur : cur;
        endcase
        return r;
    endfunction

    always_comb begin
        st_d   = st_q;
        // reserved positions carry no storage, so host writes there vanish
        if (i_glob_wr) begin
            st_d.glob = i_glob_wdata;
        end
        // status flags follow monitors only, never the write ports; active_input follows the input choice policy
        st_d.stat.input_a_fail_flag    = i_input_a_bad;
        st_d.stat.input_b_fail_flag    = i_input_b_bad;
        st_d.stat.crystal_fail_flag    = i_crystal_bad;
        st_d.stat.pll_locked_flag      = i_pll_locked;
        st_d.stat.frozen_tracking_flag = i_pd_out_of_spec;
        st_d.stat.active_input = pick_input(st_q.glob.input_choice_policy,
            st_q.glob.clock_choice, i_input_sel_pin, st_q.stat.active_input,
            i_input_a_bad, i_input_b_bad);
        st_d.active_cfg = sel_now;
        st_d.cfg_act    = sel_now ? cfg1 : cfg0;
        st_d.mode       = decode_mode(st_q.glob.pll_mode);
        st_d.out_a_on   = st_q.glob.out_a_enable & i_out_a_en_pin;
        st_d.out_b_on   = st_q.glob.out_b_enable & i_out_b_en_pin;
        st_d.adc_div    = 5'(1 << (ADC_SHIFT0 - 3'(st_q.glob.adc_rate)));
        st_d.win_cyc    = 10'(LOCK_WINDOW_FIELD_BASE_CYC
                          << st_q.glob.lock_window_field);
    end

    // register select only counts once the source bit hands it control
    assign sel_now = st_q.glob.cfg_from_reg ? st_q.glob.cfg_reg_sel
                                            : i_config_pin;

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            st_q <= '{glob: GLOB_RST, stat: STAT_RST, active_cfg: 1'b0,
                      cfg_act: CFG_RST, mode: TCS_LBW, out_a_on: 1'b0,
                      out_b_on: 1'b0, adc_div: 5'(1 << ADC_SHIFT0),
                      win_cyc: 10'(LOCK_WINDOW_FIELD_BASE_CYC)};
        end else if (i_ce) begin
            st_q <= st_d;
        end
    end

    assign o_cfg0             = cfg0;
    assign o_cfg1             = cfg1;
    assign o_glob             = st_q.glob;
    assign o_stat             = st_q.stat;
    assign o_active_cfg       = st_q.active_cfg;
    assign o_cfg_active       = st_q.cfg_act;
    assign o_mode             = st_q.mode;
    assign o_out_a_on         = st_q.out_a_on;
    assign o_out_b_on         = st_q.out_b_on;
    assign o_out_a_lvds       = st_q.cfg_act.out_a_signalling_sel;
    assign o_out_b_lvds       = st_q.cfg_act.out_b_signalling_sel;
    assign o_lower_loop_used  = (st_q.mode == TCS_LBW);
    assign o_adc_div          = st_q.adc_div;
    assign o_lock_win_cyc     = st_q.win_cyc;
    assign o_crystal_x2       = st_q.glob.crystal_doubler;
    assign o_osc_freeze       = st_q.stat.frozen_tracking_flag;
    assign o_input_a_fail_pin = st_q.stat.input_a_fail_flag;
    assign o_input_b_fail_pin = st_q.stat.input_b_fail_flag;
    assign o_crystal_fail_pin = st_q.stat.crystal_fail_flag;
    assign o_lock_pin         = st_q.stat.pll_locked_flag;
    assign o_frozen_tracking_flag_pin     = st_q.stat.frozen_tracking_flag;
    assign o_active_input_pin = st_q.stat.active_input;

    property p_out_a_gate;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        i_ce |=> (o_out_a_on == ($past(st_q.glob.out_a_enable)
                                 & $past(i_out_a_en_pin)));
    endproperty
    a_out_a_gate: assert property (p_out_a_gate)
        else $error("output a enable not gated by bit and pin");

    property p_out_b_gate;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (i_ce && !st_q.glob.out_b_enable) |=> !o_out_b_on;
    endproperty
    a_out_b_gate: assert property (p_out_b_gate)
        else $error("output b on while its enable bit is low");

    property p_cfg_pin;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (i_ce && !st_q.glob.cfg_from_reg) |=> (o_active_cfg
                                                == $past(i_config_pin));
    endproperty
    a_cfg_pin: assert property (p_cfg_pin)
        else $error("pin source not followed");

    property p_cfg_reg;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (i_ce && st_q.glob.cfg_from_reg) |=> (o_active_cfg
                                               == $past(st_q.glob.cfg_reg_sel));
    endproperty
    a_cfg_reg: assert property (p_cfg_reg)
        else $error("register select not followed");

    property p_set_pick;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (i_ce && !i_cfg0_wr && !i_cfg1_wr) |=>
            (o_cfg_active == (o_active_cfg ? $past(cfg1) : $past(cfg0)));
    endproperty
    a_set_pick: assert property (p_set_pick)
        else $error("active set differs from selected set");

    property p_mode;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (i_ce && st_q.glob.pll_mode[1]) |=> (o_mode == TCS_HBW);
    endproperty
    a_mode: assert property (p_mode)
        else $error("high bandwidth code not decoded");

    property p_lock_pin;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        i_ce |=> (o_lock_pin == $past(i_pll_locked));
    endproperty
    a_lock_pin: assert property (p_lock_pin)
        else $error("lock pin does not follow lock");

    property p_fail_clear;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (i_ce && !i_input_a_bad && !i_crystal_bad) |=>
            (!o_input_a_fail_pin && !o_stat.crystal_fail_flag);
    endproperty
    a_fail_clear: assert property (p_fail_clear)
        else $error("fail flag did not self clear");

    property p_win;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (i_ce && st_q.glob.lock_window_field == WIN_SHIFT_MAX) |=>
            (o_lock_win_cyc == 10'(LOCK_WINDOW_FIELD_BASE_CYC * 8));
    endproperty
    a_win: assert property (p_win)
        else $error("16 us window count wrong");

    property p_lvds_pick;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        i_ce |=> (o_out_a_lvds == ($past(sel_now)
                                   ? $past(cfg1.out_a_signalling_sel)
                                   : $past(cfg0.out_a_signalling_sel)));
    endproperty
    a_lvds_pick: assert property (p_lvds_pick)
        else $error("output a signalling not taken from active set");

    // divider times two to the code is always the slowest ratio
    property p_adc_div;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        i_ce |=> ((int'(o_adc_div) << $past(st_q.glob.adc_rate))
                  == (1 << ADC_SHIFT0));
    endproperty
    a_adc_div: assert property (p_adc_div)
        else $error("adc divider does not match rate code");

    property p_frozen_tracking_flag;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        i_ce |=> (o_osc_freeze == $past(i_pd_out_of_spec)
                  && o_frozen_tracking_flag_pin == $past(i_pd_out_of_spec));
    endproperty
    a_frozen_tracking_flag: assert property (p_frozen_tracking_flag)
        else $error("frozen_tracking_flag flag or freeze does not follow detector");

    property p_stat_ro;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (i_ce && (i_glob_wr || i_cfg0_wr || i_cfg1_wr)) |=>
            (o_stat[5:1] == $past({i_input_a_bad, i_input_b_bad,
                                   i_crystal_bad, i_pll_locked,
                                   i_pd_out_of_spec}));
    endproperty
    a_stat_ro: assert property (p_stat_ro)
        else $error("status flags disturbed by a write");

    property p_reg_pick;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (i_ce && st_q.glob.input_choice_policy == POL_REG) |=>
            (o_active_input_pin == $past(st_q.glob.clock_choice));
    endproperty
    a_reg_pick: assert property (p_reg_pick)
        else $error("register manual choice not followed");

    property p_revert;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (i_ce && st_q.glob.input_choice_policy == POL_REV
         && !i_input_a_bad && !i_input_b_bad) |=>
            (o_active_input_pin == $past(st_q.glob.clock_choice));
    endproperty
    a_revert: assert property (p_revert)
        else $error("revertive mode left the good primary input");
endmodule
`default_nettype wire

// ---- verification/tcs_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module tcs_host_model
    import tcs_pkg::*;
(
    // clock
    input  wire logic i_core_clk,
    // write side toward the bank
    output logic      o_cfg0_wr,
    output logic      o_cfg1_wr,
    output tcs_cfg_t  o_cfg_wdata,
    output logic      o_glob_wr,
    output tcs_glob_t o_glob_wdata
);
    initial begin
        o_cfg0_wr    = 1'b0;
        o_cfg1_wr    = 1'b0;
        o_cfg_wdata  = CFG_RST;
        o_glob_wr    = 1'b0;
        o_glob_wdata = GLOB_RST;
    end

    // strobe spans exactly one rising edge; released data is inverted
    // so a bank that samples late sees garbage, not the old value
    task automatic wr_cfg(input logic set, input tcs_cfg_t d);
        @(negedge i_core_clk);
        o_cfg0_wr   = ~set;
        o_cfg1_wr   = set;
        o_cfg_wdata = d;
        @(negedge i_core_clk);
        o_cfg0_wr   = 1'b0;
        o_cfg1_wr   = 1'b0;
        o_cfg_wdata = ~d;
    endtask

    // struct carries defined fields only, reserved positions stay zero
    task automatic wr_glob(input tcs_glob_t d);
        @(negedge i_core_clk);
        o_glob_wr    = 1'b1;
        o_glob_wdata = d;
        @(negedge i_core_clk);
        o_glob_wr    = 1'b0;
        o_glob_wdata = ~d;
    endtask
endmodule
`default_nettype wire

// ---- verification/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
    import tcs_pkg::*;
    logic      clk, rst_n, ce, cfg0_wr, cfg1_wr, glob_wr;
    logic      cfg_pin, a_pin, b_pin, sel_pin, a_bad, b_bad, x_bad, lck, pd;
    tcs_cfg_t  cfg_wd, cfg0, cfg1, cfg_act;
    tcs_glob_t glob_wd, glob, g;
    tcs_stat_t stat;
    tcs_mode_t mode;
    logic      act_cfg, a_on, b_on, a_lvds, b_lvds, low_used, x2, frz;
    logic      p_a, p_b, p_x, p_l, p_h, p_act;
    logic [4:0] adc_div;
    logic [9:0] win;
    int        mismatches, cmp_count;
    tcs_cfg_t  pa, pb;

    tcs_host_model u_host (.i_core_clk(clk), .o_cfg0_wr(cfg0_wr),
        .o_cfg1_wr(cfg1_wr), .o_cfg_wdata(cfg_wd), .o_glob_wr(glob_wr),
        .o_glob_wdata(glob_wd));

    tcs_bank u_dut (.i_core_clk(clk), .i_rst_n(rst_n), .i_ce(ce),
        .i_cfg0_wr(cfg0_wr), .i_cfg1_wr(cfg1_wr), .i_cfg_wdata(cfg_wd),
        .i_glob_wr(glob_wr), .i_glob_wdata(glob_wd), .i_config_pin(cfg_pin),
        .i_out_a_en_pin(a_pin), .i_out_b_en_pin(b_pin),
        .i_input_sel_pin(sel_pin), .i_input_a_bad(a_bad),
        .i_input_b_bad(b_bad), .i_crystal_bad(x_bad), .i_pll_locked(lck),
        .i_pd_out_of_spec(pd), .o_cfg0(cfg0), .o_cfg1(cfg1), .o_glob(glob),
        .o_stat(stat), .o_active_cfg(act_cfg), .o_cfg_active(cfg_act),
        .o_mode(mode), .o_out_a_on(a_on), .o_out_b_on(b_on),
        .o_out_a_lvds(a_lvds), .o_out_b_lvds(b_lvds),
        .o_lower_loop_used(low_used), .o_adc_div(adc_div),
        .o_lock_win_cyc(win), .o_crystal_x2(x2), .o_osc_freeze(frz),
        .o_input_a_fail_pin(p_a), .o_input_b_fail_pin(p_b),
        .o_crystal_fail_pin(p_x), .o_lock_pin(p_l), .o_frozen_tracking_flag_pin(p_h),
        .o_active_input_pin(p_act));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic wg();
        u_host.wr_glob(g);
        wt(3);
    endtask

    task automatic mon(input logic [4:0] v);
        {a_bad, b_bad, x_bad, lck, pd} = v;
        wt(3);
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        wt(20000);
        mismatches++;
        results();
    end

    initial begin
        mismatches = 0;
        cmp_count = 0;
        {rst_n, ce, cfg_pin, a_pin, b_pin, sel_pin} = 6'h10;
        {a_bad, b_bad, x_bad, lck, pd} = 5'h00;
        g = GLOB_RST;
        pa = {1'b1, 1'b0, 17'h1ABCD, 17'h0F0F1, 8'hA5, 18'h2C3D4, 11'h5E6, 7'h3B};
        pb = ~pa;
        wt(12);
        rst_n = 1'b1;
        wt(1);
        chk(glob, GLOB_RST);
        chk({adc_div, win, mode}, {5'h10, 10'h032, TCS_LBW});
        $display("test reset done");
        // sets, selection by pin then register
        u_host.wr_cfg(1'b0, pa);
        u_host.wr_cfg(1'b1, pb);
        wt(3);
        chk({cfg0, cfg1}, {pa, pb});
        chk({act_cfg, cfg_act, a_lvds, b_lvds}, {1'b0, pa, 2'h1});
        cfg_pin = 1'b1;
        wt(3);
        chk({act_cfg, cfg_act, a_lvds, b_lvds}, {1'b1, pb, 2'h2});
        g.cfg_reg_sel = 1'b0;
        g.cfg_from_reg = 1'b1;
        wg();
        chk({act_cfg, cfg_act}, {1'b0, pa});
        g.cfg_from_reg = 1'b0;
        wg();
        chk(act_cfg, 1'b1);
        ce = 1'b0;
        u_host.wr_cfg(1'b0, pb);
        wt(3);
        chk(cfg0, pa);
        ce = 1'b1;
        $display("test sets done");
        for (int k = 0; k < 4; k++) begin
            g.pll_mode = k[1:0];
            g.adc_rate = k[1:0];
            g.lock_window_field = k[1:0];
            g.crystal_doubler = k[0];
            wg();
            chk(mode, (k == 0) ? TCS_LBW : (k == 1) ? TCS_SYNTH : TCS_HBW);
            chk(low_used, k == 0);
            chk(adc_div, 5'h10 >> k);
            chk(win, 10'(LOCK_WINDOW_FIELD_BASE_CYC << k));
            chk(x2, k[0]);
        end
        $display("test codes done");
        for (int k = 0; k < 16; k++) begin
            {g.out_a_enable, a_pin, g.out_b_enable, b_pin} = k[3:0];
            wg();
            chk(a_on, k[3] & k[2]);
            chk(b_on, k[1] & k[0]);
        end
        $display("test enables done");
        for (int k = 0; k < 5; k++) begin
            mon(5'h10 >> k);
            chk({stat[5:1], frz}, {5'h10 >> k, k == 4});
            chk({p_a, p_b, p_x, p_l, p_h}, 5'h10 >> k);
        end
        g.crystal_doubler = 1'b0;
        wg();
        chk(stat[5:1], 5'h01);
        mon(5'h00);
        $display("test status done");
        g.input_choice_policy = POL_REG;
        g.clock_choice = 1'b1;
        wg();
        chk({stat.active_input, p_act}, 2'h3);
        g.input_choice_policy = POL_PIN;
        g.clock_choice = 1'b0;
        sel_pin = 1'b1;
        wg();
        chk(p_act, 1'b1);
        sel_pin = 1'b0;
        g.input_choice_policy = POL_REV;
        wg();
        chk(p_act, 1'b0);
        mon(5'h10);
        chk(p_act, 1'b1);
        mon(5'h00);
        chk(p_act, 1'b0);
        g.input_choice_policy = POL_NONREV;
        wg();
        mon(5'h10);
        mon(5'h00);
        chk(p_act, 1'b1);
        mon(5'h08);
        chk({stat.active_input, p_act}, 2'h0);
        $display("test input choice done");
        results();
    end
endmodule
`default_nettype wire
